/* hdl/phts_map.svh */
// constants for the power-up and halt/trap selection block
`ifndef PHTS_MAP_SVH
`define PHTS_MAP_SVH
`define PHTS_ADDR_W        22
`define PHTS_MEM_LIMIT     23'h080000
`define PHTS_PC_LOC        22'h000014
`define PHTS_PSW_LOC       22'h000016
`define PHTS_HALT_VEC      22'h000008
`define PHTS_CHAIN_N       8
`endif

/* hdl/phts_pkg.sv */
// types for the power-up and halt/trap selection block
`default_nettype none
package phts_pkg;
  typedef enum logic [1:0] {
    PHTS_MODE_VECTOR  = 2'b00,
    PHTS_MODE_MONITOR = 2'b01,
    PHTS_MODE_BOOT    = 2'b10,
    PHTS_MODE_EXTMC   = 2'b11
  } phts_mode_t;
  typedef enum logic [1:0] {
    PHTS_HALT_NONE    = 2'b00,
    PHTS_HALT_MONITOR = 2'b01,
    PHTS_HALT_TRAP    = 2'b10
  } phts_halt_t;
  typedef enum logic [1:0] {
    PHTS_ST_RESET = 2'b00,
    PHTS_ST_START = 2'b01,
    PHTS_ST_RUN   = 2'b10
  } phts_state_t;
endpackage : phts_pkg
`default_nettype wire

/* hdl/phts_grant_chain.sv */
// daisy-chained bus grant passing in slot order
`timescale 1ns/1ps
`default_nettype none
module phts_grant_chain #(
  parameter int N = 8
) (
  input  wire logic         grant_in,
  input  wire logic [N-1:0] request,
  output logic      [N-1:0] grant_out,
  output logic      [N-1:0] claim
);
  logic [N:0] pass;
  always_comb begin
    pass[0] = grant_in;
    for (int i = 0; i < N; i++) begin
      claim[i]     = pass[i] & request[i];   // RQ6
      grant_out[i] = pass[i] & ~request[i];  // RQ5
      pass[i+1]    = grant_out[i];           // RQ5
    end
  end
endmodule : phts_grant_chain
`default_nettype wire

/* hdl/phts_top.sv */
// power-up mode, halt/trap selection, grant chain and address limit
// Summary of operation
// RQ1 - two straps pick start: vector at 24/26, monitor, bootstrap, extended microcode
// RQ2 - strap removed: kernel halt enters the console debug monitor
// RQ3 - strap installed: kernel halt traps through vector 10 octal
// RQ4 - user-mode halt always traps to 10 octal, strap ignored
// RQ5 - grant passes serially slot by slot unless a module claims it
// RQ6 - module nearer the processor wins when several request together
// RQ7 - 22-bit addresses, physical memory limited to 512K bytes
// RQ8 - straps sampled at reset release, held until next srst reset
`timescale 1ns/1ps
`default_nettype none
`include "phts_map.svh"
module phts_top #(
  parameter int N = `PHTS_CHAIN_N
) (
  input  wire logic                     ref_clk,
  input  wire logic                     srst,
  input  wire logic [1:0]               mode_strap,
  input  wire logic                     halt_trap_strap,
  input  wire logic                     halt_exec,
  input  wire logic                     user_mode,
  input  wire logic                     grant_in,
  input  wire logic [N-1:0]             request,
  input  wire logic [`PHTS_ADDR_W-1:0]  phys_addr,
  output var phts_pkg::phts_mode_t      start_mode,
  output logic                          start_valid,
  output logic [`PHTS_ADDR_W-1:0]       start_pc_addr,
  output logic [`PHTS_ADDR_W-1:0]       start_psw_addr,
  output var phts_pkg::phts_halt_t      halt_action,
  output logic [`PHTS_ADDR_W-1:0]       trap_vector,
  output logic [N-1:0]                  grant_out,
  output logic [N-1:0]                  claim,
  output logic                          addr_in_range
);
  import phts_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic phts_mode_t strap_mode(
    input logic [1:0] straps
  );
    phts_mode_t m;
    case (straps)
      2'h0: begin
        m = PHTS_MODE_VECTOR;                        // RQ1
      end
      2'h1: begin
        m = PHTS_MODE_MONITOR;                       // RQ1
      end
      2'h2: begin
        m = PHTS_MODE_BOOT;                          // RQ1
      end
      2'h3: begin
        m = PHTS_MODE_EXTMC;                         // RQ1
      end
      default: begin
        m = PHTS_MODE_VECTOR;
      end
    endcase
    return m;
  endfunction : strap_mode
  function automatic phts_halt_t halt_select(
    input logic user,
    input logic trap_inst
  );
    phts_halt_t sel;
    if (user) begin
      sel = PHTS_HALT_TRAP;                          // RQ4
    end else if (trap_inst) begin
      sel = PHTS_HALT_TRAP;                          // RQ3
    end else begin
      sel = PHTS_HALT_MONITOR;                       // RQ2
    end
    return sel;
  endfunction : halt_select
  function automatic logic below_limit(
    input logic [`PHTS_ADDR_W-1:0] addr
  );
    logic [`PHTS_ADDR_W:0] wide;
    wide = {1'b0, addr};
    return (wide < `PHTS_MEM_LIMIT);                 // RQ7
  endfunction : below_limit
  ////////////////////////////////////////////////////////////////////////////
  // strap synchronisers
  logic [1:0] mode_s1;
  logic [1:0] mode_s2;
  logic [1:0] next_mode_s1;
  logic [1:0] next_mode_s2;
  logic       ht_s1;
  logic       ht_s2;
  logic       next_ht_s1;
  logic       next_ht_s2;
  always_comb begin
    next_mode_s1 = mode_strap;
    next_mode_s2 = mode_s1;
    next_ht_s1   = halt_trap_strap;
    next_ht_s2   = ht_s1;
  end
  always_ff @(posedge ref_clk) begin
    mode_s1 <= next_mode_s1;
    mode_s2 <= next_mode_s2;
    ht_s1   <= next_ht_s1;
    ht_s2   <= next_ht_s2;
  end
  ////////////////////////////////////////////////////////////////////////////
  // start-up sequence
  phts_state_t state;
  phts_state_t next_state;
  phts_mode_t  mode;
  phts_mode_t  next_mode;
  logic        ht_inst;
  logic        next_ht_inst;
  logic        valid;
  logic        next_valid;
  always_comb begin
    next_state   = state;
    next_mode    = mode;
    next_ht_inst = ht_inst;
    next_valid   = 1'b0;
    case (state)
      PHTS_ST_RESET: begin
        next_state = PHTS_ST_START;
      end
      PHTS_ST_START: begin
        next_mode    = strap_mode(mode_s2);    // RQ8
        next_ht_inst = ht_s2;                  // RQ8
        next_valid   = 1'b1;
        next_state   = PHTS_ST_RUN;
      end
      PHTS_ST_RUN: begin
        next_state = PHTS_ST_RUN;
      end
      default: begin
        next_state = PHTS_ST_RESET;
      end
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state   <= PHTS_ST_RESET;
      mode    <= PHTS_MODE_VECTOR;
      ht_inst <= 1'b0;
      valid   <= 1'b0;
    end else begin
      state   <= next_state;
      mode    <= next_mode;
      ht_inst <= next_ht_inst;
      valid   <= next_valid;
    end
  end
  assign start_mode     = mode;                      // RQ1
  assign start_valid    = valid;
  assign start_pc_addr  = `PHTS_PC_LOC;              // RQ1
  assign start_psw_addr = `PHTS_PSW_LOC;             // RQ1
  ////////////////////////////////////////////////////////////////////////////
  // halt handling
  phts_halt_t act;
  phts_halt_t next_act;
  logic       halt_taken;
  always_comb begin
    next_act   = PHTS_HALT_NONE;
    halt_taken = halt_exec && (state == PHTS_ST_RUN);
    if (halt_taken) begin
      next_act = halt_select(user_mode, ht_inst);
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      act <= PHTS_HALT_NONE;
    end else begin
      act <= next_act;
    end
  end
  assign halt_action = act;
  assign trap_vector = `PHTS_HALT_VEC;               // RQ3
  ////////////////////////////////////////////////////////////////////////////
  // grant chain and address range
  phts_grant_chain #(.N(N)) u_chain (
    .grant_in  (grant_in),
    .request   (request),
    .grant_out (grant_out),
    .claim     (claim)
  );
  assign addr_in_range = below_limit(phys_addr);                 // RQ7
endmodule : phts_top
`default_nettype wire

/* testbench/phts_props.sv */
// checker for the selection block
`timescale 1ns/1ps
`default_nettype none
module phts_props import phts_pkg::*; #(
  parameter int N = 8
) (
  input wire logic         ref_clk,
  input wire logic         srst,
  input wire logic         halt_exec,
  input wire logic         user_mode,
  input wire logic         halt_trap_strap,
  input wire logic         grant_in,
  input wire logic         start_valid,
  input wire logic         addr_in_range,
  input wire logic [N-1:0] request,
  input wire logic [N-1:0] grant_out,
  input wire logic [N-1:0] claim,
  input wire logic [21:0]  phys_addr,
  input wire phts_mode_t   start_mode,
  input wire phts_halt_t   halt_action
);
  logic run;
  logic ht_cap;
  always_ff @(posedge ref_clk) run <= !srst && (run || start_valid);
  always_ff @(posedge ref_clk) ht_cap <= start_valid ? halt_trap_strap : ht_cap;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_k; run && halt_exec && !user_mode; endsequence
  property p_usr; run && halt_exec && user_mode |=> halt_action == PHTS_HALT_TRAP; endproperty
  a_usr: assert property (p_usr) else $error("user halt");
  property p_trp; s_k ##0 ht_cap |=> halt_action == PHTS_HALT_TRAP; endproperty
  a_trp: assert property (p_trp) else $error("kernel trap");
  property p_mon; s_k ##0 !ht_cap |=> halt_action == PHTS_HALT_MONITOR; endproperty
  a_mon: assert property (p_mon) else $error("kernel monitor");
  property p_sv; $fell(srst) |-> ##[1:3] start_valid; endproperty
  a_sv: assert property (p_sv) else $error("no start");
  property p_md; run |-> $stable(start_mode); endproperty
  a_md: assert property (p_md) else $error("mode moved");
  property p_clm; claim == (grant_in ? request & (~request + 1'b1) : '0); endproperty
  a_clm: assert property (p_clm) else $error("claim");
  property p_gnt; grant_out == (grant_in ? ~(request | (~request + 1'b1)) : '0); endproperty
  a_gnt: assert property (p_gnt) else $error("grant pass");
  property p_adr; addr_in_range == (phys_addr < 22'h080000); endproperty
  a_adr: assert property (p_adr) else $error("range");
  cover property (halt_action == PHTS_HALT_MONITOR);
  cover property (halt_action == PHTS_HALT_TRAP);
  cover property (claim[1]);
endmodule : phts_props
`default_nettype wire

/* testbench/phts_slots.sv */
// slot modules asking for the bus
`timescale 1ns/1ps
`default_nettype none
module phts_slots #(parameter int N = 8) (
  input  wire logic         ref_clk,
  input  wire logic         srst,
  input  wire logic [N-1:0] want,
  input  wire logic [N-1:0] claim,
  output var logic  [N-1:0] request
);
  always_ff @(posedge ref_clk) request <= srst ? '0 : (request | want) & ~claim;
endmodule : phts_slots
`default_nettype wire

/* testbench/tb_phts_top.sv */
// bench for the selection block
`timescale 1ns/1ps
`default_nettype none
module tb_phts_top;
  import phts_pkg::*;
  logic ref_clk = 0, srst = 1, halt_trap_strap = 0, halt_exec = 0, user_mode = 0, grant_in = 0;
  logic [1:0] mode_strap = 0;
  logic [7:0] want = 0, request, grant_out, claim;
  logic [21:0] phys_addr = 0, start_pc_addr, start_psw_addr, trap_vector;
  phts_mode_t start_mode;
  phts_halt_t halt_action;
  logic start_valid, addr_in_range;
  int fails = 0, num_checks = 0, i, j;
  always #25 ref_clk = ~ref_clk;
  phts_top uut (
    .ref_clk         (ref_clk),
    .srst            (srst),
    .mode_strap      (mode_strap),
    .halt_trap_strap (halt_trap_strap),
    .halt_exec       (halt_exec),
    .user_mode       (user_mode),
    .grant_in        (grant_in),
    .request         (request),
    .phys_addr       (phys_addr),
    .start_mode      (start_mode),
    .start_valid     (start_valid),
    .start_pc_addr   (start_pc_addr),
    .start_psw_addr  (start_psw_addr),
    .halt_action     (halt_action),
    .trap_vector     (trap_vector),
    .grant_out       (grant_out),
    .claim           (claim),
    .addr_in_range   (addr_in_range)
  );
  phts_slots slots (.ref_clk, .srst, .want, .claim, .request);
  task chk(input logic [47:0] seen, exp, input string nm);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  task boot(input logic [1:0] m);
    mode_strap = m;
    srst = 1;
    repeat (5) @(negedge ref_clk);
    srst = 0;
    for (i = 0; i < 9 && start_valid !== 1'b1; i++) @(negedge ref_clk);
    if (i == 9) begin
      fails++;
      wrap_up;
    end
  endtask : boot
  task t_start;
    for (j = 0; j < 4; j++) begin
      boot(j[1:0]);
      mode_strap = ~j[1:0];
      repeat (4) @(negedge ref_clk);
      chk(start_mode, j, "mode");
      chk({start_pc_addr, start_psw_addr}, {22'h14, 22'h16}, "locs");
    end
    $display("start done");
  endtask : t_start
  task t_halt;
    for (j = 0; j < 2; j++) begin
      halt_trap_strap = j[0];
      boot(2'h0);
      repeat (2) @(negedge ref_clk);
      halt_exec = 1;
      user_mode = 0;
      @(negedge ref_clk);
      if (j == 0) chk(halt_action, PHTS_HALT_MONITOR, "kernel halt");
      else chk(halt_action, PHTS_HALT_TRAP, "kernel halt");
      user_mode = 1;
      halt_trap_strap = !j[0];
      @(negedge ref_clk);
      chk(halt_action, PHTS_HALT_TRAP, "user halt");
      user_mode = 0;
      @(negedge ref_clk);
      if (j == 0) chk(halt_action, PHTS_HALT_MONITOR, "latched strap");
      else chk(halt_action, PHTS_HALT_TRAP, "latched strap");
      halt_exec = 0;
      @(negedge ref_clk);
      chk({halt_action, trap_vector}, {PHTS_HALT_NONE, 22'h8}, "idle");
    end
    $display("halt done");
  endtask : t_halt
  task t_chain;
    grant_in = 1;
    want = 8'h06;
    @(negedge ref_clk);
    want = 0;
    chk({claim, grant_out}, 16'h0201, "chain");
    @(negedge ref_clk);
    chk({claim, grant_out}, 16'h0403, "chain");
    grant_in = 0;
    #1 chk({claim, grant_out}, 16'h0, "chain");
    @(negedge ref_clk);
    grant_in = 1;
    @(negedge ref_clk);
    chk({claim, grant_out}, 16'h00FF, "chain");
    @(negedge ref_clk);
    phys_addr = 22'h07FFFF;
    #1 chk(addr_in_range, 1'b1, "range");
    @(negedge ref_clk);
    phys_addr = 22'h080000;
    #1 chk(addr_in_range, 1'b0, "range");
    @(negedge ref_clk);
    phys_addr = 22'h3FFFFF;
    #1 chk(addr_in_range, 1'b0, "range");
    $display("chain done");
  endtask : t_chain
  initial begin
    t_start;
    t_halt;
    t_chain;
    wrap_up;
  end
endmodule : tb_phts_top
bind phts_top phts_props #(.N(N)) chk_i (
  .ref_clk         (ref_clk),
  .srst            (srst),
  .halt_exec       (halt_exec),
  .user_mode       (user_mode),
  .halt_trap_strap (halt_trap_strap),
  .grant_in        (grant_in),
  .start_valid     (start_valid),
  .addr_in_range   (addr_in_range),
  .request         (request),
  .grant_out       (grant_out),
  .claim           (claim),
  .phys_addr       (phys_addr),
  .start_mode      (start_mode),
  .halt_action     (halt_action)
);
`default_nettype wire
